/* core/iepb_pkg.sv */
// Package for the interrupt enable and priority register bank
`default_nettype none

package iepb_pkg;
  localparam logic [3:0] IEPB_ADDR_EN0 = 4'h0;
  localparam logic [3:0] IEPB_ADDR_EN2 = 4'h1;
  localparam logic [3:0] IEPB_ADDR_EN3 = 4'h2;
  localparam logic [3:0] IEPB_ADDR_PRI1 = 4'h3;
  localparam logic [3:0] IEPB_ADDR_STAT = 4'h4;
  localparam logic [3:0] IEPB_ADDR_MASK = 4'h5;
  // Writable bit masks
  localparam logic [15:0] IEPB_EN0_MASK = 16'hB9CD;
  localparam logic [15:0] IEPB_EN2_MASK = 16'h0020;
  localparam logic [15:0] IEPB_EN3_MASK = 16'h0006;
  localparam logic [15:0] IEPB_PRI1_MASK = 16'h7700;
  localparam logic [15:0] IEPB_EN_RESET = 16'h0000;
  localparam logic [15:0] IEPB_PRI1_RESET = 16'h4400;
  localparam int IEPB_T2_PRI_LSB = 12;
  localparam int IEPB_CP2_PRI_LSB = 8;
  localparam int IEPB_T2_BIT = 7;
  localparam int IEPB_CP2_BIT = 6;
  // Request vector layout: 0..15 group0 bits, 16 timer3 gate, 17 ser2 event, 18 ser2 collision
  localparam int IEPB_NSRC = 19;
  localparam int IEPB_SRC_T3G = 16;
  localparam int IEPB_SRC_S2EV = 17;
  localparam int IEPB_SRC_S2BC = 18;
  localparam logic [2:0] IEPB_DEF_PRI = 3'h4;
  localparam logic [2:0] IEPB_PRI_OFF = 3'h0;
endpackage

`default_nettype wire

/* core/iepb_bank.sv */
// Interrupt enable and priority register bank with request gating
`default_nettype none

module iepb_bank
  import iepb_pkg::*;
#(
  parameter bit HAS_SERIAL2 = 1'b1
)
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [IEPB_NSRC-1:0] src_req,
  output logic [IEPB_NSRC-1:0] irq_pass,
  output logic irq_valid,
  output logic [4:0] irq_id,
  output logic [2:0] irq_level,
  output logic irq_out
);

  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // Group3 enables exist only with the second serial port
  logic [15:0] en3_mask;
  assign en3_mask = HAS_SERIAL2 ? IEPB_EN3_MASK : 16'h0000;

  // One write strobe per register; status and unmapped take no write
  logic wr_en0;
  logic wr_en2;
  logic wr_en3;
  logic wr_pri1;
  logic wr_mask;
  logic rd_stat;

  always_comb
  begin
    wr_en0 = 1'b0;
    wr_en2 = 1'b0;
    wr_en3 = 1'b0;
    wr_pri1 = 1'b0;
    wr_mask = 1'b0;
    if (reg_wr)
    begin
      if (reg_addr == IEPB_ADDR_EN0)
      begin
        wr_en0 = 1'b1;
      end
      else if (reg_addr == IEPB_ADDR_EN2)
      begin
        wr_en2 = 1'b1;
      end
      else if (reg_addr == IEPB_ADDR_EN3)
      begin
        wr_en3 = 1'b1;
      end
      else if (reg_addr == IEPB_ADDR_PRI1)
      begin
        wr_pri1 = 1'b1;
      end
      else if (reg_addr == IEPB_ADDR_MASK)
      begin
        wr_mask = 1'b1;
      end
    end
  end

  assign rd_stat = reg_rd && (reg_addr == IEPB_ADDR_STAT);

  // Group0 enables
  logic [15:0] en0_q;
  logic [15:0] en0_d;

  always_comb
  begin
    en0_d = en0_q;
    if (wr_en0)
    begin
      en0_d = reg_wdata & IEPB_EN0_MASK;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      en0_q <= IEPB_EN_RESET;
    end
    else
    begin
      en0_q <= en0_d;
    end
  end

  // Group2 and group3 enables
  logic [15:0] en2_q;
  logic [15:0] en2_d;
  logic [15:0] en3_q;
  logic [15:0] en3_d;

  always_comb
  begin
    en2_d = en2_q;
    en3_d = en3_q;
    if (wr_en2)
    begin
      en2_d = reg_wdata & IEPB_EN2_MASK;
    end
    if (wr_en3)
    begin
      en3_d = reg_wdata & en3_mask;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      en2_q <= IEPB_EN_RESET;
      en3_q <= IEPB_EN_RESET;
    end
    else
    begin
      en2_q <= en2_d;
      en3_q <= en3_d;
    end
  end

  // Priority fields
  logic [15:0] pri1_q;
  logic [15:0] pri1_d;

  always_comb
  begin
    pri1_d = pri1_q;
    if (wr_pri1)
    begin
      pri1_d = reg_wdata & IEPB_PRI1_MASK;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      pri1_q <= IEPB_PRI1_RESET;
    end
    else
    begin
      pri1_q <= pri1_d;
    end
  end

  // Interrupt mask; only the low 16 bits are reachable
  logic [IEPB_NSRC-1:0] mask_q;
  logic [IEPB_NSRC-1:0] mask_d;

  always_comb
  begin
    mask_d = mask_q;
    if (wr_mask)
    begin
      mask_d = {{(IEPB_NSRC - 16){1'b0}}, reg_wdata};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      mask_q <= {IEPB_NSRC{1'b0}};
    end
    else
    begin
      mask_q <= mask_d;
    end
  end

  // Enable vector in request layout
  logic [IEPB_NSRC-1:0] en_vec;
  assign en_vec = {en3_q[2], en3_q[1], en2_q[5], en0_q};

  logic [IEPB_NSRC-1:0] pass;
  assign pass = src_req & en_vec;

  // Per-source priority: group1 fields for timer2/compare2, default otherwise
  logic [2:0] pri [IEPB_NSRC];
  genvar gi;
  generate
    for (gi = 0; gi < IEPB_NSRC; gi++)
    begin : g_pri
      if (gi == IEPB_T2_BIT)
      begin : g_t2
        assign pri[gi] = pri1_q[IEPB_T2_PRI_LSB +: 3];
      end
      else if (gi == IEPB_CP2_BIT)
      begin : g_cp2
        assign pri[gi] = pri1_q[IEPB_CP2_PRI_LSB +: 3];
      end
      else
      begin : g_def
        assign pri[gi] = IEPB_DEF_PRI;
      end
    end
  endgenerate

  // Highest code wins; a tie goes to the lowest index
  logic best_v;
  logic [4:0] best_id;
  logic [2:0] best_pri;

  always_comb
  begin
    best_v = 1'b0;
    best_id = 5'h00;
    best_pri = IEPB_PRI_OFF;
    for (int i = 0; i < IEPB_NSRC; i++)
    begin
      if (pass[i] && pri[i] != IEPB_PRI_OFF && (!best_v || pri[i] > best_pri))
      begin
        best_v = 1'b1;
        best_id = 5'(i);
        best_pri = pri[i];
      end
    end
  end

  // Sticky event status
  logic [IEPB_NSRC-1:0] stat_q;
  logic [IEPB_NSRC-1:0] stat_d;

  always_comb
  begin
    stat_d = stat_q;
    if (rd_stat)
    begin
      stat_d = {IEPB_NSRC{1'b0}};
    end
    // New events win over the read clear
    stat_d = stat_d | pass;
  end

  always_ff @(posedge clk_sys or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      stat_q <= {IEPB_NSRC{1'b0}};
    end
    else
    begin
      stat_q <= stat_d;
    end
  end

  // Presentation stage towards the core
  logic [IEPB_NSRC-1:0] irq_pass_d;
  logic irq_valid_d;
  logic [4:0] irq_id_d;
  logic [2:0] irq_level_d;
  logic irq_out_d;

  always_comb
  begin
    irq_pass_d = pass;
    irq_valid_d = best_v;
    irq_id_d = best_id;
    irq_level_d = best_pri;
    irq_out_d = |(stat_d & mask_d);
  end

  always_ff @(posedge clk_sys or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      irq_pass <= {IEPB_NSRC{1'b0}};
      irq_valid <= 1'b0;
      irq_id <= 5'h00;
      irq_level <= 3'h0;
      irq_out <= 1'b0;
    end
    else
    begin
      irq_pass <= irq_pass_d;
      irq_valid <= irq_valid_d;
      irq_id <= irq_id_d;
      irq_level <= irq_level_d;
      irq_out <= irq_out_d;
    end
  end

  // Read data, zero outside the read slot and for unmapped addresses
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;

  always_comb
  begin
    rdata_d = 16'h0000;
    if (reg_rd)
    begin
      if (reg_addr == IEPB_ADDR_EN0)
      begin
        rdata_d = en0_q;
      end
      else if (reg_addr == IEPB_ADDR_EN2)
      begin
        rdata_d = en2_q;
      end
      else if (reg_addr == IEPB_ADDR_EN3)
      begin
        rdata_d = en3_q;
      end
      else if (reg_addr == IEPB_ADDR_PRI1)
      begin
        rdata_d = pri1_q;
      end
      else if (reg_addr == IEPB_ADDR_STAT)
      begin
        rdata_d = stat_q[15:0];
      end
      else if (reg_addr == IEPB_ADDR_MASK)
      begin
        rdata_d = mask_q[15:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      rdata_q <= 16'h0000;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

endmodule

`default_nettype wire

/* verification/iepb_src_model.sv */
// Peripheral source model driving request levels
`default_nettype none
module iepb_src_model
  import iepb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [IEPB_NSRC-1:0] raise,
  output logic [IEPB_NSRC-1:0] src_req
);
  always_ff @(posedge clk_sys)
    src_req <= raise;
endmodule
`default_nettype wire

/* verification/iepb_bank_assertions.sv */
// Port checker for the enable and priority bank
`default_nettype none
module iepb_chk
  import iepb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [18:0] src_req,
  input wire logic [18:0] irq_pass,
  input wire logic irq_valid,
  input wire logic [4:0] irq_id,
  input wire logic [2:0] irq_level,
  input wire logic irq_out
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  a_pass_gated: assert property ((irq_pass & ~$past(src_req)) == '0)
    else $error("pass without request");
  a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read slot");
  a_en0_bits: assert property ($past(reg_rd && reg_addr == IEPB_ADDR_EN0)
    |-> (reg_rdata & ~IEPB_EN0_MASK) == 16'h0000) else $error("group0 spare bit");
  a_en2_bits: assert property ($past(reg_rd && reg_addr == IEPB_ADDR_EN2)
    |-> (reg_rdata & ~IEPB_EN2_MASK) == 16'h0000) else $error("group2 spare bit");
  a_en3_bits: assert property ($past(reg_rd && reg_addr == IEPB_ADDR_EN3)
    |-> (reg_rdata & ~IEPB_EN3_MASK) == 16'h0000) else $error("group3 spare bit");
  a_pri_bits: assert property ($past(reg_rd && reg_addr == IEPB_ADDR_PRI1)
    |-> (reg_rdata & ~IEPB_PRI1_MASK) == 16'h0000) else $error("priority spare bit");
  a_unmapped_zero: assert property ($past(reg_rd && reg_addr > 4'h5)
    |-> reg_rdata == 16'h0000) else $error("unmapped read not zero");
  a_level_nonzero: assert property (irq_valid |-> irq_level != 3'h0)
    else $error("disabled level presented");
  a_id_passed: assert property (irq_valid |-> irq_pass[irq_id])
    else $error("presented source not passed");
  cover property (irq_valid);
  cover property (irq_out);
  cover property ($past(reg_rd) && reg_rdata != 16'h0000);
endmodule
bind iepb_bank iepb_chk u_chk (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_req(src_req), .irq_pass(irq_pass),
  .irq_valid(irq_valid), .irq_id(irq_id), .irq_level(irq_level), .irq_out(irq_out));
`default_nettype wire

/* verification/tb.sv */
// Self-checking bench for the enable and priority bank
`default_nettype none
module tb
  import iepb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, irq_valid, irq_out;
  logic [3:0] reg_addr = '0;
  logic [15:0] reg_wdata = '0, reg_rdata;
  logic [15:0] ns_rdata;
  logic [18:0] raise = '0, src_req, irq_pass;
  logic [4:0] irq_id;
  logic [2:0] irq_level;
  int n_mismatch = 0, checks = 0, cyc = 0;
  logic [3:0] ra[7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'hF};
  logic [15:0] rz[7] = '{16'h0, 16'h0, 16'h0, IEPB_PRI1_RESET, 16'h0, 16'h0, 16'h0};
  logic [15:0] r1[7] = '{IEPB_EN0_MASK, IEPB_EN2_MASK, IEPB_EN3_MASK, IEPB_PRI1_MASK,
    16'hFFFF, 16'h0, 16'h0};
  iepb_src_model u_src (.clk_sys(clk_sys), .raise(raise), .src_req(src_req));
  iepb_bank u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .src_req(src_req), .irq_pass(irq_pass), .irq_valid(irq_valid), .irq_id(irq_id),
    .irq_level(irq_level), .irq_out(irq_out));
  iepb_bank #(.HAS_SERIAL2(1'b0)) u_dut_ns (.clk_sys(clk_sys), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(ns_rdata), .src_req(src_req), .irq_pass(), .irq_valid(), .irq_id(),
    .irq_level(), .irq_out());
  initial
    forever #50 clk_sys = ~clk_sys;
  task automatic complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [18:0] got, input logic [18:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
    chk(ns_rdata, (a == IEPB_ADDR_EN3) ? 16'h0000 : e);
    @(posedge clk_sys);
  endtask
  task automatic settle;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 500)
    begin
      n_mismatch++;
      complete_run();
    end
  end
  initial
  begin
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    foreach (ra[i])
    begin
      rd(ra[i], rz[i]);
      wr(ra[i], 16'hFFFF);
      rd(ra[i], r1[i]);
    end
    wr(IEPB_ADDR_EN2, 16'h0000);
    wr(IEPB_ADDR_EN3, 16'h0000);
    wr(IEPB_ADDR_EN0, 16'h00C0);
    wr(IEPB_ADDR_PRI1, 16'h1700);
    raise <= '1;
    settle();
    chk(irq_pass, 19'h000C0);
    chk({irq_valid, irq_id, irq_level}, {1'b1, 5'h06, 3'h7});
    chk(irq_out, 1'b1);
    @(posedge clk_sys);
    wr(IEPB_ADDR_PRI1, 16'h7000);
    settle();
    chk({irq_valid, irq_id, irq_level}, {1'b1, 5'h07, 3'h7});
    @(posedge clk_sys);
    raise <= '0;
    wr(IEPB_ADDR_MASK, 16'h0000);
    settle();
    chk(irq_out, 1'b0);
    @(posedge clk_sys);
    rd(IEPB_ADDR_STAT, 16'h00C0);
    wr(IEPB_ADDR_MASK, 16'h00C0);
    settle();
    chk(irq_out, 1'b0);
    @(posedge clk_sys);
    raise <= '1;
    settle();
    chk({irq_valid, irq_id, irq_level, irq_out}, {1'b1, 5'h07, 3'h7, 1'b1});
    @(posedge clk_sys);
    rd(IEPB_ADDR_STAT, 16'h00C0);
    #1;
    chk(irq_out, 1'b1);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk(irq_pass, '0);
    chk({irq_valid, irq_out}, 2'b00);
    @(posedge clk_sys);
    reset_n <= 1'b1;
    settle();
    chk(irq_pass, '0);
    chk(irq_out, 1'b0);
    @(posedge clk_sys);
    rd(IEPB_ADDR_EN0, IEPB_EN_RESET);
    rd(IEPB_ADDR_PRI1, IEPB_PRI1_RESET);
    complete_run();
  end
endmodule
`default_nettype wire
